// File: logic/sar_adc_pkg.sv
// Purpose: Shared constants for the successive approximation conversion control.
// Assumes: Core clock of 100 MHz; converter clock, start and comparator arrive as pins.
// Notes: Host-side timing figures are kept here so the margins can be checked against the clock.
package sar_adc_pkg;

  localparam int RES_BITS = 10;
  localparam int IDX_W = 4;
  localparam logic [RES_BITS-1:0] RESULT_RESET = 10'h000;
  localparam logic [RES_BITS-1:0] APPROX_INIT = 10'h200;
  localparam logic [IDX_W-1:0] MSB_IDX = 4'h9;
  localparam logic [IDX_W-1:0] LSB_IDX = 4'h0;

  // Pin inputs and their positions in the synchroniser bank.
  localparam int PIN_COUNT = 3;
  localparam int PIN_CONV_CLK = 0;
  localparam int PIN_START_N = 1;
  localparam int PIN_COMP_BELOW = 2;
  localparam logic [PIN_COUNT-1:0] PIN_RESET = 3'h3;

  // Core clock and host-side start pulse timing.
  localparam int CLK_PERIOD_NS = 10;
  localparam int START_LEAD_NS = 2000;
  localparam int START_LEAD_CYC = (START_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int START_GUARD_NS = 200;
  localparam int START_GUARD_CYC = START_GUARD_NS / CLK_PERIOD_NS;

  // Serial bit buffer geometry.
  localparam int BUF_WIDTH = 1;
  localparam int BUF_DEPTH = 2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARM = 2'b01,
    ST_CONV = 2'b11,
    ST_TAIL = 2'b10
  } conv_state_e;

endpackage

// File: logic/sar_bit_buffer.sv
// Purpose: Two-entry buffer for decided result bits on their way to the serial output.
// Assumes: Single clock, synchronous active-low reset, clock enable freezes all state.
// Notes: Full and empty are exact, so the conversion stalls rather than drop a bit.
`timescale 1ns/1ps
module sar_bit_buffer
  import sar_adc_pkg::*;
#(
  parameter int WIDTH = BUF_WIDTH,
  parameter int DEPTH = BUF_DEPTH
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wrPtr_reg;
  logic [PW-1:0] rdPtr_reg;
  logic [PW:0] count_reg;
  logic [PW-1:0] wrPtr_next;
  logic [PW-1:0] rdPtr_next;
  logic [PW:0] count_next;
  wire push;
  wire pop;

  assign inReady = (count_reg != (PW+1)'(DEPTH));
  assign outValid = (count_reg != '0);
  assign outData = mem_reg[rdPtr_reg];
  assign push = inValid & inReady;
  assign pop = outValid & outReady;
  assign wrPtr_next = (wrPtr_reg == PW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
  assign rdPtr_next = (rdPtr_reg == PW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
  assign count_next = count_reg + (PW+1)'(push) - (PW+1)'(pop);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else if (ce) begin
      if (push) begin
        wrPtr_reg <= wrPtr_next;
      end
      if (pop) begin
        rdPtr_reg <= rdPtr_next;
      end
      count_reg <= count_next;
    end
  end

  // Storage needs no reset; empty entries are never presented as valid.
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem_reg[wrPtr_reg] <= inData;
    end
  end

endmodule // sar_bit_buffer

// File: logic/sar_adc_conversion_control.sv
// Purpose: Control logic of a 10-bit successive approximation converter.
// Assumes: Converter clock, start and comparator decision arrive as asynchronous pins.
// Notes: All pins pass a three-stage synchroniser, so actions lag the pin edges by a few cycles.
`timescale 1ns/1ps

// Overview of operation
// - Ten-bit result by successive approximation.
// - Start loads MSB one, others zero.
// - Status goes low when conversion starts.
// - First falling edge decides the MSB.
// - Each edge decides one bit, trials next.
// - Status rises on eleventh falling edge.
// - Decided bits leave serially with strobe.
module sar_adc_conversion_control
  import sar_adc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic convClk,
  input wire logic startN,
  input wire logic compBelow,
  input wire logic serialReady,
  output logic [RES_BITS-1:0] result,
  output logic status,
  output logic serialData,
  output logic serial_bit_strobe,
  output logic bufferStall
);

  // Pin synchronisers: a change is accepted only once stages two and three agree.
  logic [PIN_COUNT-1:0] pinsIn;
  logic [PIN_COUNT-1:0] sync1_reg;
  logic [PIN_COUNT-1:0] sync2_reg;
  logic [PIN_COUNT-1:0] sync3_reg;
  logic [PIN_COUNT-1:0] filt_reg;
  logic [PIN_COUNT-1:0] filtPrev_reg;

  assign pinsIn[PIN_CONV_CLK] = convClk;
  assign pinsIn[PIN_START_N] = startN;
  assign pinsIn[PIN_COMP_BELOW] = compBelow;

  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (!nrst) begin
          sync1_reg[gi] <= PIN_RESET[gi];
          sync2_reg[gi] <= PIN_RESET[gi];
          sync3_reg[gi] <= PIN_RESET[gi];
          filt_reg[gi] <= PIN_RESET[gi];
          filtPrev_reg[gi] <= PIN_RESET[gi];
        end else if (ce) begin
          sync1_reg[gi] <= pinsIn[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          sync3_reg[gi] <= sync2_reg[gi];
          if (sync2_reg[gi] == sync3_reg[gi]) begin
            filt_reg[gi] <= sync3_reg[gi];
          end
          filtPrev_reg[gi] <= filt_reg[gi];
        end
      end
    end
  endgenerate

  wire convFall;
  wire startLow;
  wire startFall;
  wire compIsBelow;

  assign convFall = filtPrev_reg[PIN_CONV_CLK] & ~filt_reg[PIN_CONV_CLK];
  assign startFall = filtPrev_reg[PIN_START_N] & ~filt_reg[PIN_START_N];
  assign startLow = ~filt_reg[PIN_START_N];
  assign compIsBelow = filt_reg[PIN_COMP_BELOW];

  // Conversion sequencer.
  conv_state_e state_reg;
  conv_state_e state_next;
  logic [RES_BITS-1:0] approx_reg;
  logic [RES_BITS-1:0] approx_next;
  logic [IDX_W-1:0] bitIdx_reg;
  logic [IDX_W-1:0] bitIdx_next;
  logic status_reg;
  logic status_next;
  logic pendFall_reg;
  logic pendFall_next;

  // A falling converter edge that meets a full buffer is held here until there is room.
  wire fallSeen;
  wire bufInReady;
  wire decideNow;
  wire tailNow;
  wire consume;
  wire decidedBit;
  wire lastBit;
  logic [RES_BITS-1:0] decideMask;
  logic [RES_BITS-1:0] trialMask;

  assign fallSeen = convFall | pendFall_reg;
  assign decideNow = (state_reg == ST_CONV) & fallSeen & bufInReady;
  assign tailNow = (state_reg == ST_TAIL) & fallSeen;
  assign consume = decideNow | tailNow;
  assign decidedBit = ~compIsBelow;
  assign lastBit = (bitIdx_reg == LSB_IDX);
  assign decideMask = RES_BITS'(1) << bitIdx_reg;
  assign trialMask = lastBit ? '0 : (decideMask >> 1);

  always_comb begin
    state_next = state_reg;
    approx_next = approx_reg;
    bitIdx_next = bitIdx_reg;
    status_next = status_reg;
    pendFall_next = (state_reg == ST_CONV) ? (fallSeen & ~consume) : 1'b0;
    if (startLow) begin
      // Start held low keeps the register initialised; edges only act after release.
      state_next = ST_ARM;
      approx_next = APPROX_INIT;
      bitIdx_next = MSB_IDX;
      status_next = 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          state_next = ST_IDLE;
        end
        ST_ARM: begin
          state_next = ST_CONV;
        end
        ST_CONV: begin
          if (decideNow) begin
            // Decide the current bit and place the trial one below it on the same edge.
            approx_next = (decidedBit ? approx_reg : (approx_reg & ~decideMask)) | trialMask;
            bitIdx_next = lastBit ? LSB_IDX : bitIdx_reg - 1'b1;
            if (lastBit) begin
              state_next = ST_TAIL;
            end
          end
        end
        ST_TAIL: begin
          if (tailNow) begin
            status_next = 1'b1;
            state_next = ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      approx_reg <= RESULT_RESET;
      bitIdx_reg <= MSB_IDX;
      status_reg <= 1'b1;
      pendFall_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      approx_reg <= approx_next;
      bitIdx_reg <= bitIdx_next;
      status_reg <= status_next;
      pendFall_reg <= pendFall_next;
    end
  end

  // Serial stream: decided bits queue in a small buffer so a slow receiver loses nothing.
  wire bufOutValid;
  wire bufPop;
  logic [BUF_WIDTH-1:0] bufOutData;
  logic [BUF_WIDTH-1:0] bufInData;
  logic popDly_reg;

  assign bufInData = BUF_WIDTH'(decidedBit);
  // Pops are spaced two cycles apart, so the data never moves while the strobe is high.
  // This halves the serial rate, which is still far above the converter edge rate.
  assign bufPop = bufOutValid & serialReady & ~popDly_reg;

  sar_bit_buffer #(
    .WIDTH(BUF_WIDTH),
    .DEPTH(BUF_DEPTH)
  ) u_bit_buffer (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .inValid(decideNow),
    .inReady(bufInReady),
    .inData(bufInData),
    .outValid(bufOutValid),
    .outReady(bufPop),
    .outData(bufOutData)
  );

  logic serialData_reg;
  logic strobe_reg;
  logic stall_reg;
  wire stallNow;

  assign stallNow = (state_reg == ST_CONV) & fallSeen & ~bufInReady;

  // Data is loaded one cycle ahead of the strobe so it is settled at the strobe's rising edge.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      serialData_reg <= 1'b0;
      popDly_reg <= 1'b0;
      strobe_reg <= 1'b0;
      stall_reg <= 1'b0;
    end else if (ce) begin
      if (bufPop) begin
        serialData_reg <= bufOutData[0];
      end
      popDly_reg <= bufPop;
      strobe_reg <= popDly_reg;
      stall_reg <= stallNow;
    end
  end

  assign result = approx_reg;
  assign status = status_reg;
  assign serialData = serialData_reg;
  assign serial_bit_strobe = strobe_reg;
  assign bufferStall = stall_reg;

endmodule // sar_adc_conversion_control

// File: testbench/sar_adc_properties.sv
// Purpose: Port checker for the conversion control.
// Assumes: ce held high; converter clock phases last many core cycles.
// Notes: Pin paths lag a few cycles, so decisions are judged ten cycles after a raw edge.
`timescale 1ns/1ps
module sar_adc_properties
  import sar_adc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic convClk,
  input wire logic startN,
  input wire logic compBelow,
  input wire logic serialReady,
  input wire logic [RES_BITS-1:0] result,
  input wire logic status,
  input wire logic serialData,
  input wire logic serial_bit_strobe,
  input wire logic bufferStall
);
  logic ckPrev;
  logic [3:0] fallCnt;
  logic [7:0] since;
  logic [RES_BITS-1:0] trial;
  assign trial = APPROX_INIT >> fallCnt;
  always_ff @(posedge clk) begin
    ckPrev <= convClk;
    if (!nrst || !startN) fallCnt <= 4'h0;
    else if (ckPrev && !convClk) fallCnt <= fallCnt + 4'h1;
    if (!nrst) since <= 8'hFF;
    else if (ckPrev && !convClk) since <= 8'h00;
    else if (since != 8'hFF) since <= since + 8'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_init; (!startN)[*8] |=> result == APPROX_INIT; endproperty
  property p_busy; (!startN)[*8] |=> !status; endproperty
  property p_msb; serialReady[*8] ##0 (since == 8'h0A && fallCnt == 4'h1) |-> result[9] == !$past(compBelow, 11);
  endproperty
  property p_trial; serialReady[*8] ##0 (since == 8'h0A && fallCnt inside {[1:9]})
    |-> (result & (trial | (trial - 1'b1))) == trial; endproperty
  property p_done; $rose(status) |-> fallCnt == 4'hB && since < 8'h0C; endproperty
  property p_strobe; serial_bit_strobe |-> $past(serialReady, 2); endproperty
  property p_data; $changed(serialData) |=> $rose(serial_bit_strobe); endproperty
  property p_settle; serial_bit_strobe |-> $stable(serialData); endproperty
  property p_hold; status && startN |=> status && $stable(result); endproperty
  a_init: assert property (p_init) else $error("start load wrong");
  a_busy: assert property (p_busy) else $error("busy missing");
  a_msb: assert property (p_msb) else $error("top bit decision wrong");
  a_trial: assert property (p_trial) else $error("trial bit wrong");
  a_done: assert property (p_done) else $error("done edge wrong");
  a_strobe: assert property (p_strobe) else $error("strobe without ready");
  a_data: assert property (p_data) else $error("data moved off strobe");
  a_settle: assert property (p_settle) else $error("data not settled at strobe");
  a_hold: assert property (p_hold) else $error("result not held");
  c_done: cover property ($rose(status));
  c_stall: cover property (bufferStall);
  c_strobe: cover property (serial_bit_strobe);
endmodule // sar_adc_properties

bind sar_adc_conversion_control sar_adc_properties chk (.clk(clk), .nrst(nrst), .convClk(convClk),
  .startN(startN), .compBelow(compBelow), .serialReady(serialReady), .result(result), .status(status),
  .serialData(serialData), .serial_bit_strobe(serial_bit_strobe), .bufferStall(bufferStall));

// File: testbench/sar_host_model.sv
// Purpose: Host and analogue side: start pulse, converter clock, comparator.
// Assumes: Core clock of 10 ns; one frame per go pulse.
// Notes: Converter clock rests high between frames.
`timescale 1ns/1ps
module sar_host_model
  import sar_adc_pkg::*;
(
  input wire logic clk,
  input wire logic go,
  input wire logic [RES_BITS-1:0] target,
  input wire logic [RES_BITS-1:0] result,
  output logic convClk,
  output logic startN,
  output logic compBelow,
  output logic busy
);
  // The input current is below the trial output whenever the trial overshoots.
  assign compBelow = result > target;
  initial begin
    convClk = 1'b1;
    startN = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (go) begin
        busy <= 1'b1;
        startN <= 1'b0;
        repeat (START_LEAD_CYC + 10) @(posedge clk);
        startN <= 1'b1;
        repeat (11) begin
          repeat (30) @(posedge clk);
          convClk <= 1'b0;
          repeat (30) @(posedge clk);
          convClk <= 1'b1;
        end
        busy <= 1'b0;
      end
    end
  end
endmodule // sar_host_model

// File: testbench/tb.sv
// Purpose: Self-checking bench for the conversion control.
// Assumes: ce held high; host model makes all pin timing.
// Notes: One stalled conversion fills the bit buffer until it refuses.
`timescale 1ns/1ps
module tb;
  import sar_adc_pkg::*;
  logic clk, nrst, serialReady, go, convClk, startN, compBelow, busy;
  logic status, serialData, serial_bit_strobe, bufferStall, stallSeen;
  logic [RES_BITS-1:0] result, target, bits;
  int err_total = 0, tests_run = 0, nbits = 0, cycles = 0;

  sar_adc_conversion_control dut (.clk(clk), .nrst(nrst), .ce(1'b1), .convClk(convClk), .startN(startN),
    .compBelow(compBelow), .serialReady(serialReady), .result(result), .status(status),
    .serialData(serialData), .serial_bit_strobe(serial_bit_strobe), .bufferStall(bufferStall));
  sar_host_model host (.clk(clk), .go(go), .target(target), .result(result), .convClk(convClk),
    .startN(startN), .compBelow(compBelow), .busy(busy));

  task automatic finish_test();
    $display("errors %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [RES_BITS-1:0] exp, input logic [RES_BITS-1:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", name, exp, got);
    end
  endtask

  task automatic chk_flag(input string name, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %b got %b", name, exp, got);
    end
  endtask

  task automatic t_convert(input logic [RES_BITS-1:0] code, input logic stall);
    int n;
    @(posedge clk);
    target <= code;
    serialReady <= !stall;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (20) @(posedge clk);
    chk("init", APPROX_INIT, result);
    chk_flag("busy", 1'b0, status);
    // Released before the fourth converter fall so the one remembered fall is not overrun.
    if (stall) begin
      repeat (370) @(posedge clk);
      serialReady <= 1'b1;
    end
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    chk_flag("frame end", 1'b0, busy);
    repeat (20) @(posedge clk);
    chk("result", code, result);
    chk_flag("status", 1'b1, status);
    chk("serial", code, bits);
    chk("count", 10'h00A, RES_BITS'(nbits));
    chk_flag("stall", stall, stallSeen);
    repeat (50) @(posedge clk);
    chk("hold", code, result);
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    // Counters are cleared here on the go pulse so that only this process drives them.
    if (go === 1'b1) begin
      nbits <= 0;
      stallSeen <= 1'b0;
    end else begin
      if (serial_bit_strobe === 1'b1) begin
        bits <= {bits[RES_BITS-2:0], serialData};
        nbits <= nbits + 1;
      end
      if (bufferStall === 1'b1) stallSeen <= 1'b1;
    end
    if (cycles == 10000) begin
      err_total++;
      finish_test();
    end
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    nrst = 1'b0;
    serialReady = 1'b1;
    go = 1'b0;
    target = 10'h000;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    chk("rst result", 10'h000, result);
    chk_flag("rst status", 1'b1, status);
    repeat (4) @(posedge clk);
    t_convert(10'h3FF, 1'b0);
    t_convert(10'h000, 1'b0);
    t_convert(10'h2AA, 1'b1);
    t_convert(10'h155, 1'b0);
    finish_test();
  end
endmodule // tb
